/* hdl/bppp_pkg.sv */
// bppp_pkg: shared constants and types for the bidirectional parallel peripheral port
// assumes a single 250 MHz clock domain
package bppp_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int ACK_PULSE_NS = 8;
  localparam int ACK_PULSE_CYC = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_NS = 8;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] ACK_CNT_LOAD = 4'(ACK_PULSE_CYC);
  localparam logic [3:0] SETUP_CNT_LOAD = 4'(SETUP_CYC);
  // ==========================================================
  // widths and reset values
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  localparam int MEM_ADDR_W = 16;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] ADDR_ONE = 16'h0001;
  // ==========================================================
  // states
  typedef enum logic [2:0] {BPPP_F_IDLE, BPPP_F_STORE, BPPP_F_WAIT_MEM, BPPP_F_ACK,
                            BPPP_F_WAIT_STB_HI} bppp_fwd_t;
  typedef enum logic [2:0] {BPPP_R_IDLE, BPPP_R_WAIT_LO1, BPPP_R_SETUP1, BPPP_R_WAIT_HI1,
                            BPPP_R_WAIT_LO2, BPPP_R_SETUP2, BPPP_R_WAIT_HI2} bppp_rev_t;
endpackage

/* hdl/bppp_buf2.sv */
// bppp_buf2: two-entry valid/ready buffer in front of the memory write port
// assumes the drain side may hold ready low for any time
`timescale 1ns/1ps
`default_nettype none
module bppp_buf2
  import bppp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [BYTE_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [BYTE_W-1:0] out_data
);
  // ==========================================================
  // storage
  logic [BYTE_W-1:0] mem0;
  logic [BYTE_W-1:0] mem1;
  logic [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem0;
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 2'h0;
      mem0 <= BYTE_RESET;
      mem1 <= BYTE_RESET;
    end else begin
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
      if (pop) begin
        mem0 <= (count == 2'h2) ? mem1 : in_data;
      end
      if (push && (count == 2'h0 || (count == 2'h1 && pop))) begin
        mem0 <= in_data;
      end else if (push) begin
        mem1 <= in_data;
      end
    end
  end
  property p_no_overflow;
    @(posedge clk) disable iff (rst) (count == 2'h2) |-> !push;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer overflow");
  property p_first_slot;
    @(posedge clk) disable iff (rst) (count == 2'h0) && push && !pop
      |=> out_valid && out_data == $past(in_data);
  endproperty
  a_first_slot: assert property (p_first_slot) else $error("first slot lost"); // [R5]
endmodule
`default_nettype wire

/* hdl/bppp_top.sv */
// bppp_top: peripheral end of a byte-wide parallel port, compatibility and nibble modes
// assumes host pins already synchronous to clk; memory write port answers with wr_done
// Functional notes
// [R1] compatibility forward and nibble reverse modes supported
// [R2] forward data accepted as whole bytes
// [R3] host drives byte then pulls strobe low
// [R4] strobe fall raises busy, latches data
// [R5] latched byte written to receive buffer
// [R6] ack pulse, busy low after write
// [R7] reverse byte sent as two nibbles
// [R8] data available low while reverse data ready
// [R9] host busy fall: low nibble, clock low
// [R10] host takes nibble, then raises busy
// [R11] second busy fall sends high nibble
// [R12] no more data: raise available, idle
// [R13] clock low marks high nibble, returns high
// [R14] nibble stable until host raises busy
`timescale 1ns/1ps
`default_nettype none
module bppp_top
  import bppp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic nibble_mode,
  input wire logic [BYTE_W-1:0] host_data,
  input wire logic data_strobe_n,
  output logic busy,
  output logic byte_accepted_pulse_n,
  output logic mem_wr_en,
  output logic [MEM_ADDR_W-1:0] mem_wr_addr,
  output logic [BYTE_W-1:0] mem_wr_data,
  input wire logic mem_wr_done,
  input wire logic rev_valid,
  output logic rev_ready,
  input wire logic [BYTE_W-1:0] rev_data,
  input wire logic host_busy,
  output logic data_avail_n,
  output logic periph_clk,
  output logic [NIB_W-1:0] status_nibble
);
  // ==========================================================
  // forward channel
  bppp_fwd_t fstate;
  bppp_fwd_t next_fstate;
  logic strobe_d;
  logic [BYTE_W-1:0] hold;
  logic [3:0] ack_cnt;
  logic buf_out_valid;
  logic buf_in_ready;
  logic [BYTE_W-1:0] buf_out_data;
  logic mem_busy;
  wire strobe_fall = strobe_d && !data_strobe_n;
  wire fwd_on = !nibble_mode; // [R1]
  wire start_fwd = fwd_on && strobe_fall && fstate == BPPP_F_IDLE;
  wire buf_push = fstate == BPPP_F_STORE;
  wire buf_pop = buf_out_valid && !mem_busy;
  // ack only after the memory write of this byte completes, so busy covers the whole store
  wire fwd_written = fstate == BPPP_F_WAIT_MEM && !buf_out_valid && !mem_busy;
  always_comb begin
    next_fstate = fstate;
    case (fstate)
      BPPP_F_IDLE: if (start_fwd) next_fstate = BPPP_F_STORE;
      BPPP_F_STORE: if (buf_in_ready) next_fstate = BPPP_F_WAIT_MEM;
      BPPP_F_WAIT_MEM: if (fwd_written) next_fstate = BPPP_F_ACK; // [R6]
      BPPP_F_ACK: if (ack_cnt == CNT_ZERO) next_fstate = BPPP_F_WAIT_STB_HI;
      BPPP_F_WAIT_STB_HI: if (data_strobe_n) next_fstate = BPPP_F_IDLE;
      default: next_fstate = BPPP_F_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      fstate <= BPPP_F_IDLE;
      strobe_d <= 1'b1;
      hold <= BYTE_RESET;
      ack_cnt <= CNT_ZERO;
    end else begin
      fstate <= next_fstate;
      strobe_d <= data_strobe_n;
      if (start_fwd) hold <= host_data; // [R2] [R4]
      if (next_fstate == BPPP_F_ACK && fstate != BPPP_F_ACK) ack_cnt <= ACK_CNT_LOAD;
      else if (ack_cnt != CNT_ZERO) ack_cnt <= 4'(ack_cnt - 4'h1);
    end
  end
  assign busy = fstate != BPPP_F_IDLE && fstate != BPPP_F_WAIT_STB_HI; // [R4] [R6]
  assign byte_accepted_pulse_n = !(fstate == BPPP_F_ACK); // [R6]
  bppp_buf2 u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(hold),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );
  // ==========================================================
  // receive buffer writer
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_busy <= 1'b0;
      mem_wr_en <= 1'b0;
      mem_wr_addr <= ADDR_RESET;
      mem_wr_data <= BYTE_RESET;
    end else begin
      if (buf_pop) begin
        mem_busy <= 1'b1; // [R5]
        mem_wr_en <= 1'b1;
        mem_wr_data <= buf_out_data;
      end else if (mem_busy && mem_wr_done) begin
        mem_busy <= 1'b0;
        mem_wr_en <= 1'b0;
        mem_wr_addr <= 16'(mem_wr_addr + ADDR_ONE);
      end
    end
  end
  // ==========================================================
  // reverse channel
  bppp_rev_t rstate;
  bppp_rev_t next_rstate;
  logic [BYTE_W-1:0] rbyte;
  logic [3:0] setup_cnt;
  wire rev_take = nibble_mode && rev_valid && !host_busy &&
                  (rstate == BPPP_R_IDLE || (rstate == BPPP_R_WAIT_HI2 && host_busy));
  wire idle_take = rstate == BPPP_R_IDLE && nibble_mode && rev_valid;
  assign rev_ready = rstate == BPPP_R_IDLE && nibble_mode && !host_busy;
  always_comb begin
    next_rstate = rstate;
    case (rstate)
      BPPP_R_IDLE: if (rev_take) next_rstate = BPPP_R_SETUP1; // [R9]
      BPPP_R_SETUP1: if (setup_cnt == CNT_ZERO) next_rstate = BPPP_R_WAIT_HI1;
      BPPP_R_WAIT_HI1: if (host_busy) next_rstate = BPPP_R_WAIT_LO2; // [R10]
      BPPP_R_WAIT_LO2: if (!host_busy) next_rstate = BPPP_R_SETUP2; // [R11]
      BPPP_R_SETUP2: if (setup_cnt == CNT_ZERO) next_rstate = BPPP_R_WAIT_HI2;
      BPPP_R_WAIT_HI2: if (host_busy) next_rstate = BPPP_R_IDLE; // [R12]
      default: next_rstate = BPPP_R_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rstate <= BPPP_R_IDLE;
      rbyte <= BYTE_RESET;
      setup_cnt <= CNT_ZERO;
      status_nibble <= NIB_RESET;
    end else begin
      rstate <= next_rstate;
      if (rev_take) begin
        rbyte <= rev_data;
        status_nibble <= rev_data[3:0]; // [R7] [R9]
      end
      if (rstate == BPPP_R_WAIT_LO2 && !host_busy) status_nibble <= rbyte[7:4]; // [R11]
      if (next_rstate == BPPP_R_SETUP1 || next_rstate == BPPP_R_SETUP2) begin
        if (rstate != next_rstate) setup_cnt <= SETUP_CNT_LOAD;
        else if (setup_cnt != CNT_ZERO) setup_cnt <= 4'(setup_cnt - 4'h1);
      end
    end
  end
  // nibble set up before clock falls, held until host busy rises
  assign periph_clk = !(rstate == BPPP_R_WAIT_HI1 || rstate == BPPP_R_WAIT_HI2); // [R13] [R14]
  assign data_avail_n = !(idle_take || rstate != BPPP_R_IDLE); // [R8] [R12]
  // ==========================================================
  // checks
  sequence s_strobe_fall;
    fwd_on && strobe_fall && fstate == BPPP_F_IDLE;
  endsequence
  property p_busy_on_strobe;
    @(posedge clk) disable iff (rst) s_strobe_fall |=> busy && hold == $past(host_data);
  endproperty
  a_busy_on_strobe: assert property (p_busy_on_strobe) else $error("no busy on strobe"); // [R4]
  property p_ack_after_write;
    @(posedge clk) disable iff (rst) $fell(byte_accepted_pulse_n) |-> $past(fwd_written);
  endproperty
  a_ack_after_write: assert property (p_ack_after_write) else $error("early ack"); // [R6]
  property p_ack_width;
    @(posedge clk) disable iff (rst) $fell(byte_accepted_pulse_n) |-> !byte_accepted_pulse_n[*3];
  endproperty
  a_ack_width: assert property (p_ack_width) else $error("ack too short"); // [R6]
  property p_busy_low_after_ack;
    @(posedge clk) disable iff (rst) $rose(byte_accepted_pulse_n) |-> !busy;
  endproperty
  a_busy_low_after_ack: assert property (p_busy_low_after_ack) else $error("busy stuck"); // [R6]
  property p_mem_write;
    @(posedge clk) disable iff (rst) buf_pop |=> mem_wr_en && mem_wr_data == $past(buf_out_data);
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("bad memory write"); // [R5]
  property p_low_nibble;
    @(posedge clk) disable iff (rst) rev_take |=> status_nibble == $past(rev_data[3:0]);
  endproperty
  a_low_nibble: assert property (p_low_nibble) else $error("bad low nibble"); // [R9]
  property p_high_nibble;
    @(posedge clk) disable iff (rst) rstate == BPPP_R_WAIT_LO2 && !host_busy
      |=> status_nibble == rbyte[7:4];
  endproperty
  a_high_nibble: assert property (p_high_nibble) else $error("bad high nibble"); // [R11]
  property p_stable;
    @(posedge clk) disable iff (rst) !periph_clk |-> $stable(status_nibble);
  endproperty
  a_stable: assert property (p_stable) else $error("nibble moved"); // [R14]
  property p_clk_release;
    @(posedge clk) disable iff (rst) !periph_clk && host_busy |=> periph_clk;
  endproperty
  a_clk_release: assert property (p_clk_release) else $error("clock not released"); // [R13]
  property p_avail;
    @(posedge clk) disable iff (rst) rstate != BPPP_R_IDLE |-> !data_avail_n;
  endproperty
  a_avail: assert property (p_avail) else $error("avail high mid byte"); // [R8]
endmodule
`default_nettype wire

/* testbench/bppp_host_model.sv */
// bppp_host_model: host end of the nibble reverse channel
// assumes device outputs settle before each falling clock edge
`timescale 1ns/1ps
`default_nettype none
module bppp_host_model
  import bppp_pkg::*;
(
  input wire logic clk,
  input wire logic data_avail_n,
  input wire logic periph_clk,
  input wire logic [NIB_W-1:0] status_nibble,
  input wire logic [3:0] slow,
  output logic host_busy,
  output logic [BYTE_W-1:0] got_byte,
  output logic [7:0] got_cnt,
  output logic hold_err
);
  logic [NIB_W-1:0] nib;
  // =====
  // bounded waits: a dead device must not hang the host
  task automatic wait_pclk(input logic v);
    int i;
    for (i = 0; i < 300 && periph_clk !== v; i++) @(negedge clk);
  endtask
  task automatic take_nibble(output logic [NIB_W-1:0] n);
    wait_pclk(1'b0);
    n = status_nibble;
    repeat (slow) @(negedge clk);
    if (status_nibble !== n) hold_err = 1'b1;
    host_busy = 1'b1;
  endtask
  // =====
  // one byte per data_avail_n; busy idles high until host is ready
  initial begin
    host_busy = 1'b1;
    got_byte = 8'h00;
    got_cnt = 8'h00;
    hold_err = 1'b0;
    forever begin
      @(negedge clk);
      if (data_avail_n === 1'b0) begin
        repeat (slow) @(negedge clk);
        host_busy = 1'b0;
        take_nibble(nib);
        got_byte[3:0] = nib;
        wait_pclk(1'b1);
        host_busy = 1'b0;
        take_nibble(nib);
        got_byte[7:4] = nib;
        got_cnt = got_cnt + 8'h01;
        wait_pclk(1'b1);
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/bppp_top_bench.sv */
// bppp_top_bench: directed scenarios for forward bytes and nibble reverse
// assumes the host model drives host_busy; bench plays memory
`timescale 1ns/1ps
`default_nettype none
module bppp_top_bench;
  import bppp_pkg::*;
  logic clk, rst, nibble_mode, data_strobe_n, rev_valid;
  logic [7:0] host_data, rev_data, got_byte, got_cnt, last_data;
  logic busy, ack_n, mem_wr_en, rev_ready, host_busy, data_avail_n, periph_clk, hold_err;
  logic [15:0] mem_wr_addr, last_addr;
  logic [7:0] mem_wr_data;
  logic [3:0] status_nibble, slow;
  logic mem_wr_done = 1'b0;
  logic [7:0] wr_cnt = 8'h00;
  int lat_cnt = 0;
  int mem_lat, error_cnt, samples_checked;
  bppp_top uut (.clk(clk), .rst(rst), .nibble_mode(nibble_mode), .host_data(host_data),
    .data_strobe_n(data_strobe_n), .busy(busy), .byte_accepted_pulse_n(ack_n),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_done(mem_wr_done), .rev_valid(rev_valid), .rev_ready(rev_ready),
    .rev_data(rev_data), .host_busy(host_busy), .data_avail_n(data_avail_n),
    .periph_clk(periph_clk), .status_nibble(status_nibble));
  bppp_host_model host (.clk(clk), .data_avail_n(data_avail_n), .periph_clk(periph_clk),
    .status_nibble(status_nibble), .slow(slow), .host_busy(host_busy),
    .got_byte(got_byte), .got_cnt(got_cnt), .hold_err(hold_err));
  always #2 clk = ~clk;
  // =====
  // memory: done after mem_lat cycles, so a slow memory delays the ack and holds busy high
  always @(negedge clk) begin
    mem_wr_done <= (mem_wr_en === 1'b1 && mem_wr_done === 1'b0 && lat_cnt >= mem_lat);
    lat_cnt <= (mem_wr_en === 1'b1 && mem_wr_done === 1'b0) ? lat_cnt + 1 : 0;
  end
  always @(posedge clk) begin
    if (mem_wr_en === 1'b1 && mem_wr_done === 1'b1) begin
      wr_cnt <= wr_cnt + 8'h01;
      last_addr <= mem_wr_addr;
      last_data <= mem_wr_data;
    end
  end
  // =====
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // =====
  task automatic fwd_byte(input logic [7:0] b, input logic [15:0] a);
    int i;
    logic [7:0] n0;
    n0 = wr_cnt;
    host_data = b;
    @(negedge clk);
    data_strobe_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("busy", 16'h1, busy);
    host_data = ~b;
    data_strobe_n = 1'b1;
    for (i = 0; i < 200 && ack_n !== 1'b0; i++) @(negedge clk);
    chk("wr_cnt", n0 + 8'h01, wr_cnt);
    chk("wr_data", b, last_data);
    chk("wr_addr", a, last_addr);
    chk("busy_ack", 16'h1, busy);
    @(negedge clk);
    chk("ack_n_2nd", 16'h0, ack_n);
    @(negedge clk);
    chk("ack_n_3rd", 16'h0, ack_n);
    chk("busy_3rd", 16'h1, busy);
    @(negedge clk);
    chk("ack_n_end", 16'h1, ack_n);
    chk("busy_end", 16'h0, busy);
  endtask
  task automatic rev_send(input logic [7:0] b);
    int i;
    logic [7:0] c0;
    logic taken;
    c0 = got_cnt;
    rev_data = b;
    rev_valid = 1'b1;
    taken = 1'b0;
    // hold valid up to the edge that takes the byte, so it is sent exactly once
    for (i = 0; i < 100 && !taken; i++) begin
      @(posedge clk);
      if (i == 0) chk("avail_n_low", 16'h0, data_avail_n);
      taken = (rev_ready === 1'b1);
    end
    @(negedge clk);
    rev_valid = 1'b0;
    rev_data = ~b;
    for (i = 0; i < 500 && got_cnt === c0; i++) @(negedge clk);
    chk("rev_byte", b, got_byte);
    repeat (3) @(negedge clk);
    chk("avail_n_idle", 16'h1, data_avail_n);
    chk("pclk_idle", 16'h1, periph_clk);
    chk("hold_err", 16'h0, hold_err);
  endtask
  // =====
  // strobes in nibble mode must be ignored
  task automatic t_refuse();
    logic [7:0] n0;
    n0 = wr_cnt;
    nibble_mode = 1'b1;
    data_strobe_n = 1'b0;
    repeat (3) @(negedge clk);
    data_strobe_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("busy_nib", 16'h0, busy);
    chk("wr_nib", n0, wr_cnt);
    chk("avail_n_none", 16'h1, data_avail_n);
    $display("test refuse done");
  endtask
  initial begin
    #100000;
    error_cnt++;
    $display("[ERR] watchdog expected done seen hang");
    end_of_test();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    nibble_mode = 1'b0;
    host_data = 8'h00;
    data_strobe_n = 1'b1;
    rev_valid = 1'b0;
    rev_data = 8'h00;
    slow = 4'h0;
    mem_lat = 0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (20) @(negedge clk);
    chk("rst_out", 16'h0B, {busy, ack_n, mem_wr_en, data_avail_n, periph_clk});
    chk("rst_addr", 16'h0000, mem_wr_addr);
    rst = 1'b0;
    @(negedge clk);
    fwd_byte(8'hA5, 16'h0000);
    fwd_byte(8'h5A, 16'h0001);
    mem_lat = 6;
    fwd_byte(8'hFF, 16'h0002);
    fwd_byte(8'h00, 16'h0003);
    $display("test forward done");
    t_refuse();
    rev_send(8'h3C);
    slow = 4'h5;
    rev_send(8'hC3);
    slow = 4'h0;
    rev_send(8'h96);
    $display("test reverse done");
    end_of_test();
  end
endmodule
`default_nettype wire
